// ### rfs_pkg.sv
// constants for the rail enable and fault shutdown block
package rfs_pkg;
    timeunit 1ns;
    timeprecision 1ns;
    // register offsets
    localparam logic [7:0] ADDR_MEM_CORE_CTRL = 8'h36;
    localparam logic [7:0] ADDR_FORCED_SDWN   = 8'h49;
    localparam logic [7:0] ADDR_TERM_LDO_CTRL = 8'he9;
    localparam logic [7:0] ADDR_PG_STAT_LO    = 8'h50;
    localparam logic [7:0] ADDR_FAULT_REC_LO  = 8'h51;
    localparam logic [7:0] ADDR_FAULT_MASK_LO = 8'h52;
    localparam logic [7:0] ADDR_REG_EN        = 8'h53;
    localparam logic [7:0] ADDR_EN_SEL        = 8'h54;
    localparam logic [7:0] ADDR_STATUS        = 8'h55;
    // field positions
    localparam int TERM_PIN_MASK_BIT = 7;
    localparam int TERM_REG_EN_BIT   = 6;
    localparam int DVS_EN_BIT        = 0;
    localparam int FORCE_SDWN_BIT    = 0;
    // reset values
    localparam logic [7:0] RST_MEM_CORE_CTRL = 8'h00;
    localparam logic [7:0] RST_TERM_LDO_CTRL = 8'h00;
    localparam logic [7:0] RST_FAULT_MASK    = 8'h00;
    localparam logic [7:0] RST_EN_SEL        = 8'h00;
    // memory core voltage codes
    localparam logic [1:0] VSEL_1V20 = 2'h0;
    localparam logic [1:0] VSEL_1V35 = 2'h1;
    localparam logic [1:0] VSEL_1V10 = 2'h2;
    // timing
    localparam int CLK_HZ             = 20_000_000;
    localparam int ENABLE_BLANK_US    = 10_000;
    localparam int RESUME_BLANK_NS    = 100_000;
    localparam int DEGLITCH_NS        = 30_000;
    localparam int SDWN_MAX_NS        = 1_000;
    localparam int CLK_NS             = 1_000_000_000 / CLK_HZ;
    localparam int ENABLE_BLANK_CYC   = ENABLE_BLANK_US * (CLK_HZ / 1_000_000);
    localparam int RESUME_BLANK_CYC   = (RESUME_BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int DEGLITCH_CYC       = (DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
    localparam int SDWN_MAX_CYC       = SDWN_MAX_NS / CLK_NS;
    localparam int CCM_DCM_CYCLES     = 16;
    // switching-cycle controllers with ccm to dcm deglitch
    localparam int N_CTRL             = 4;
endpackage

// ### rfs_seq.sv
// rail enable, powergood, fault record and emergency shutdown logic
module rfs_seq #(
    parameter int N_RAILS          = 8,
    parameter int ENABLE_BLANK_CYC = rfs_pkg::ENABLE_BLANK_CYC
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    // enable and control pins
    input  wire logic [N_RAILS-1:0] regulator_enable_pin,
    input  wire logic               memory_core_enable_pin,
    input  wire logic               termination_control_input,
    input  wire logic [1:0]         memory_voltage_select_pin,
    input  wire logic               system_powergood_input,
    input  wire logic               shutdown_request_n,
    // analog monitors
    input  wire logic [N_RAILS-1:0] window_ok,
    input  wire logic [N_RAILS-1:0] rail_fault_exempt,
    input  wire logic [rfs_pkg::N_CTRL-1:0] ctrl_discontinuous,
    input  wire logic [rfs_pkg::N_CTRL-1:0] ctrl_switch_tick,
    input  wire logic               main_input_undervoltage,
    input  wire logic               aux_input_undervoltage,
    input  wire logic               die_over_temp,
    // register port
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    output logic [7:0]              reg_rdata,
    // rail controls
    output logic [N_RAILS-1:0]      rail_enable,
    output logic                    memory_core_regulator_en,
    output logic                    termination_regulator_en,
    output logic [1:0]              memory_core_vsel,
    output logic                    memory_core_dvs_low,
    output logic [rfs_pkg::N_CTRL-1:0] ctrl_pfm_mode,
    output logic [N_RAILS-1:0]      powergood,
    output logic                    shutdown_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // elaboration refuses sizes the read mux and counters cannot hold
    if (N_RAILS < 1 || N_RAILS > 8) begin : g_bad_rails
        $error("N_RAILS must be 1..8");
    end
    if (ENABLE_BLANK_CYC < 1) begin : g_bad_blank
        $error("ENABLE_BLANK_CYC must be positive");
    end

    localparam int BW = $clog2(ENABLE_BLANK_CYC + 1);
    localparam int DW = $clog2(rfs_pkg::DEGLITCH_CYC + 1);
    localparam int RW = $clog2(rfs_pkg::RESUME_BLANK_CYC + 1);

    typedef enum logic [2:0] {
        ST_RUN  = 3'b001,
        ST_DOWN = 3'b010,
        ST_OFF  = 3'b100
    } rfs_state_e;

    function automatic logic [7:0] pad8(input logic [N_RAILS-1:0] v);
        logic [7:0] r;
        r = 8'h00;
        r[N_RAILS-1:0] = v;
        return r;
    endfunction

    // pin synchronisers
    logic [N_RAILS-1:0] en_s1_q, en_s2_q, ok_s1_q, ok_s2_q;
    logic [6:0]         p_s1_q, p_s2_q;
    logic [rfs_pkg::N_CTRL-1:0] dcm_s1_q, dcm_s2_q, tk_s1_q, tk_s2_q, tk_s3_q;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            en_s1_q  <= '0;
            en_s2_q  <= '0;
            ok_s1_q  <= '0;
            ok_s2_q  <= '0;
            // idle levels, so release gives no false trip or powergood edge
            p_s1_q   <= 7'h44;
            p_s2_q   <= 7'h44;
            dcm_s1_q <= '0;
            dcm_s2_q <= '0;
            tk_s1_q  <= '0;
            tk_s2_q  <= '0;
            tk_s3_q  <= '0;
        end else begin
            en_s1_q  <= regulator_enable_pin;
            en_s2_q  <= en_s1_q;
            ok_s1_q  <= window_ok;
            ok_s2_q  <= ok_s1_q;
            p_s1_q   <= {shutdown_request_n, die_over_temp, aux_input_undervoltage,
                         main_input_undervoltage, system_powergood_input,
                         termination_control_input, memory_core_enable_pin};
            p_s2_q   <= p_s1_q;
            dcm_s1_q <= ctrl_discontinuous;
            dcm_s2_q <= dcm_s1_q;
            tk_s1_q  <= ctrl_switch_tick;
            tk_s2_q  <= tk_s1_q;
            tk_s3_q  <= tk_s2_q;
        end
    end
    logic core_pin, term_pin, sys_pg, uv_main, uv_aux, hot, sdn_n;
    assign {sdn_n, hot, uv_aux, uv_main, sys_pg, term_pin, core_pin} = p_s2_q;
    // strap stages carry no reset, so the pin is through them at release
    logic [1:0] vs_s1_q, vs_s2_q;
    always_ff @(posedge clk) begin
        vs_s1_q <= memory_voltage_select_pin;
        vs_s2_q <= vs_s1_q;
    end

    // registers
    logic [7:0] core_ctrl_q, core_ctrl_d, term_ctrl_q, term_ctrl_d;
    logic [7:0] mask_q, mask_d, reg_en_q, reg_en_d, en_sel_q, en_sel_d;
    logic       force_q, force_d;
    logic [1:0] vsel_q, vsel_d;
    logic       vsel_taken_q, vsel_taken_d;
    always_comb begin
        core_ctrl_d  = core_ctrl_q;
        term_ctrl_d  = term_ctrl_q;
        mask_d       = mask_q;
        reg_en_d     = reg_en_q;
        en_sel_d     = en_sel_q;
        force_d      = force_q;
        vsel_d       = vsel_q;
        vsel_taken_d = 1'b1;
        if (!vsel_taken_q) begin
            // strap caught once after reset release
            case (vs_s2_q)
                2'h0:    vsel_d = rfs_pkg::VSEL_1V20;
                2'h1:    vsel_d = rfs_pkg::VSEL_1V35;
                default: vsel_d = rfs_pkg::VSEL_1V10;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                rfs_pkg::ADDR_MEM_CORE_CTRL: core_ctrl_d = reg_wdata;
                rfs_pkg::ADDR_TERM_LDO_CTRL: term_ctrl_d = reg_wdata;
                rfs_pkg::ADDR_FAULT_MASK_LO: mask_d = reg_wdata;
                rfs_pkg::ADDR_REG_EN:        reg_en_d = reg_wdata;
                rfs_pkg::ADDR_EN_SEL:        en_sel_d = reg_wdata;
                rfs_pkg::ADDR_FORCED_SDWN:   force_d = reg_wdata[rfs_pkg::FORCE_SDWN_BIT];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            core_ctrl_q  <= rfs_pkg::RST_MEM_CORE_CTRL;
            term_ctrl_q  <= rfs_pkg::RST_TERM_LDO_CTRL;
            mask_q       <= rfs_pkg::RST_FAULT_MASK;
            reg_en_q     <= 8'h00;
            en_sel_q     <= rfs_pkg::RST_EN_SEL;
            force_q      <= 1'b0;
            vsel_q       <= rfs_pkg::VSEL_1V20;
            vsel_taken_q <= 1'b0;
        end else begin
            core_ctrl_q  <= core_ctrl_d;
            term_ctrl_q  <= term_ctrl_d;
            mask_q       <= mask_d;
            reg_en_q     <= reg_en_d;
            en_sel_q     <= en_sel_d;
            force_q      <= force_d;
            vsel_q       <= vsel_d;
            vsel_taken_q <= vsel_taken_d;
        end
    end

    // requested enables; rail 0 is the memory core rail
    logic [N_RAILS-1:0] req_en;
    always_comb begin
        for (int i = 0; i < N_RAILS; i++) begin
            req_en[i] = en_sel_q[i] ? reg_en_q[i] : en_s2_q[i];
        end
        if (!en_sel_q[0]) req_en[0] = core_pin;
    end

    // powergood deglitch, enable blanking and resume blanking
    logic [N_RAILS-1:0] pg_q, pg_d, on_q, on_d;
    logic [DW-1:0]      dg_q [N_RAILS];
    logic [DW-1:0]      dg_d [N_RAILS];
    logic [BW-1:0]      bl_q [N_RAILS];
    logic [BW-1:0]      bl_d [N_RAILS];
    logic [RW-1:0]      rs_q, rs_d;
    logic               sys_pg_q;
    logic [N_RAILS-1:0] fault_now;
    rfs_state_e         st_q, st_d;
    logic [N_RAILS-1:0] rec_q, rec_d;
    always_comb begin
        rs_d = rs_q;
        if (sys_pg && !sys_pg_q) rs_d = RW'(rfs_pkg::RESUME_BLANK_CYC);
        else if (rs_q != '0) rs_d = rs_q - RW'(1);
        for (int i = 0; i < N_RAILS; i++) begin
            on_d[i]  = req_en[i] && (st_q == ST_RUN);
            pg_d[i]  = pg_q[i];
            dg_d[i]  = '0;
            bl_d[i]  = bl_q[i];
            if (on_d[i] && !on_q[i]) bl_d[i] = BW'(ENABLE_BLANK_CYC);
            else if (bl_q[i] != '0) bl_d[i] = bl_q[i] - BW'(1);
            // both edges need the new level held for the full time
            if (!on_q[i]) pg_d[i] = 1'b0;
            else if (ok_s2_q[i] != pg_q[i]) begin
                if (dg_q[i] >= DW'(rfs_pkg::DEGLITCH_CYC - 1)) pg_d[i] = ok_s2_q[i];
                else dg_d[i] = dg_q[i] + DW'(1);
            end
            fault_now[i] = on_q[i] && !pg_q[i] && (bl_q[i] == '0) && (rs_q == '0)
                           && (dg_q[i] == '0) && pg_seen(i);
        end
    end
    // exempt rails never fault
    function automatic logic pg_seen(input int i);
        return !rail_fault_exempt[i];
    endfunction

    // fault record and shutdown state
    logic trip;
    always_comb begin
        rec_d = rec_q | fault_now;
        if (reg_wr && reg_addr == rfs_pkg::ADDR_FAULT_REC_LO)
            rec_d = (rec_q & ~reg_wdata[N_RAILS-1:0]) | fault_now;           // set wins
        trip = |(fault_now & ~mask_q[N_RAILS-1:0])
               || uv_main || uv_aux || hot || !sdn_n || force_q;
        st_d = st_q;
        case (st_q)
            ST_RUN:  if (trip) st_d = ST_DOWN;
            ST_DOWN: st_d = ST_OFF;
            ST_OFF:  if (!trip && req_en == '0) st_d = ST_RUN;
            default: st_d = ST_OFF;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pg_q     <= '0;
            on_q     <= '0;
            rs_q     <= '0;
            sys_pg_q <= 1'b1;
            st_q     <= ST_RUN;
            for (int i = 0; i < N_RAILS; i++) begin
                dg_q[i] <= '0;
                bl_q[i] <= '0;
            end
        end else begin
            pg_q     <= pg_d;
            on_q     <= on_d;
            rs_q     <= rs_d;
            sys_pg_q <= sys_pg;
            st_q     <= st_d;
            for (int i = 0; i < N_RAILS; i++) begin
                dg_q[i] <= dg_d[i];
                bl_q[i] <= bl_d[i];
            end
        end
    end
    // record sits in the always-on domain: cleared only by software
    always_ff @(posedge clk) begin
        rec_q <= rec_d;
    end

    // termination ldo, dvs and ccm/dcm deglitch
    logic term_en_d, term_en_q, dvs_q, dvs_d;
    logic [rfs_pkg::N_CTRL-1:0] pfm_q, pfm_d;
    logic [4:0] cc_q [rfs_pkg::N_CTRL];
    logic [4:0] cc_d [rfs_pkg::N_CTRL];
    always_comb begin
        term_en_d = (term_ctrl_q[rfs_pkg::TERM_PIN_MASK_BIT] ?
                     term_ctrl_q[rfs_pkg::TERM_REG_EN_BIT] : term_pin)
                    && (st_q == ST_RUN);
        dvs_d = core_ctrl_q[rfs_pkg::DVS_EN_BIT] && !term_pin;
        for (int i = 0; i < rfs_pkg::N_CTRL; i++) begin
            pfm_d[i] = pfm_q[i];
            cc_d[i]  = cc_q[i];
            if (!dcm_s2_q[i]) begin
                pfm_d[i] = 1'b0;
                cc_d[i]  = 5'h00;
            end else if (!pfm_q[i] && tk_s2_q[i] && !tk_s3_q[i]) begin
                if (cc_q[i] == 5'(rfs_pkg::CCM_DCM_CYCLES - 1)) pfm_d[i] = 1'b1;
                else cc_d[i] = cc_q[i] + 5'h01;
            end
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            term_en_q <= 1'b0;
            dvs_q     <= 1'b0;
            pfm_q     <= '0;
            for (int i = 0; i < rfs_pkg::N_CTRL; i++) cc_q[i] <= 5'h00;
        end else begin
            term_en_q <= term_en_d;
            dvs_q     <= dvs_d;
            pfm_q     <= pfm_d;
            for (int i = 0; i < rfs_pkg::N_CTRL; i++) cc_q[i] <= cc_d[i];
        end
    end

    // read mux, registered: data stands from the edge that takes the read
    logic [7:0] rdata_d, rdata_q;
    always_comb begin
        rdata_d = 8'h00;
        if (reg_rd) begin
            case (reg_addr)
                rfs_pkg::ADDR_MEM_CORE_CTRL: rdata_d = core_ctrl_q;
                rfs_pkg::ADDR_FORCED_SDWN:   rdata_d = {7'h00, force_q};
                rfs_pkg::ADDR_TERM_LDO_CTRL: rdata_d = term_ctrl_q;
                rfs_pkg::ADDR_PG_STAT_LO:    rdata_d = pad8(pg_q);
                rfs_pkg::ADDR_FAULT_REC_LO:  rdata_d = pad8(rec_q);
                rfs_pkg::ADDR_FAULT_MASK_LO: rdata_d = mask_q;
                rfs_pkg::ADDR_REG_EN:        rdata_d = reg_en_q;
                rfs_pkg::ADDR_EN_SEL:        rdata_d = en_sel_q;
                rfs_pkg::ADDR_STATUS:        rdata_d = {5'h00, st_q};
                default:                     rdata_d = 8'h00;
            endcase
        end
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata                = rdata_q;

    assign rail_enable              = on_q;
    assign memory_core_regulator_en = on_q[0];
    assign termination_regulator_en = term_en_q;
    assign memory_core_vsel         = vsel_q;
    assign memory_core_dvs_low      = dvs_q;
    assign ctrl_pfm_mode            = pfm_q;
    assign powergood                = pg_q;
    assign shutdown_active          = (st_q != ST_RUN);
endmodule // rfs_seq

// ### rfs_seq_checker.sv
// concurrent checks on the rail enable and fault shutdown ports
module rfs_seq_checker #(
    parameter int N_RAILS = 8
) (
    // clock and reset
    input wire logic                       clk,
    input wire logic                       resetn,
    // pins and monitors
    input wire logic                       shutdown_request_n,
    input wire logic                       memory_core_enable_pin,
    input wire logic                       system_powergood_input,
    input wire logic [N_RAILS-1:0]         rail_fault_exempt,
    input wire logic [rfs_pkg::N_CTRL-1:0] ctrl_discontinuous,
    input wire logic                       main_input_undervoltage,
    input wire logic                       aux_input_undervoltage,
    input wire logic                       die_over_temp,
    // register write port
    input wire logic                       reg_wr,
    input wire logic [7:0]                 reg_addr,
    input wire logic [7:0]                 reg_wdata,
    // outputs
    input wire logic [N_RAILS-1:0]         rail_enable,
    input wire logic                       memory_core_regulator_en,
    input wire logic                       termination_regulator_en,
    input wire logic [1:0]                 memory_core_vsel,
    input wire logic [rfs_pkg::N_CTRL-1:0] ctrl_pfm_mode,
    input wire logic [N_RAILS-1:0]         powergood,
    input wire logic                       shutdown_active
);
    timeunit 1ns;
    timeprecision 1ns;
    // raw pin edge plus margin; the design sees it two clocks later
    localparam int BLANK = rfs_pkg::RESUME_BLANK_CYC + 4;
    logic [7:0] term_q, term_d, mask_q, mask_d;
    logic       spg_q, spg_d;
    int         blank_q, blank_d;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // shadows rebuilt from writes, since only the ports are visible here
    always_comb begin
        term_d = (!resetn) ? 8'h00 : term_q;
        mask_d = (!resetn) ? 8'h00 : mask_q;
        spg_d = system_powergood_input;
        blank_d = (resetn && blank_q > 0) ? blank_q - 1 : 0;
        if (resetn && reg_wr && reg_addr == rfs_pkg::ADDR_TERM_LDO_CTRL) begin
            term_d = reg_wdata;
        end
        if (resetn && reg_wr && reg_addr == rfs_pkg::ADDR_FAULT_MASK_LO) begin
            mask_d = reg_wdata;
        end
        if (system_powergood_input && !spg_q) begin
            blank_d = BLANK;
        end
    end
    always_ff @(posedge clk) begin
        term_q <= term_d;
        mask_q <= mask_d;
        spg_q <= spg_d;
        blank_q <= blank_d;
    end
    a_sdwn_rails_off: assert property (shutdown_active |-> ##[0:20] rail_enable == '0) else $error("rails on");
    a_core_en_pin: assert property ((memory_core_enable_pin && !shutdown_active) [*4] |->
        memory_core_regulator_en) else $error("core enable");
    a_forced_sdwn_write: assert property (reg_wr && reg_addr == rfs_pkg::ADDR_FORCED_SDWN && reg_wdata[0]
        |-> ##[1:3] shutdown_active) else $error("forced shutdown missed");
    a_pin_sdwn: assert property ((!shutdown_request_n) [*3] |-> ##[0:2] shutdown_active) else $error("pin");
    a_uv_ot_sdwn: assert property ((main_input_undervoltage || aux_input_undervoltage || die_over_temp) [*3]
        |-> ##[0:2] shutdown_active) else $error("undervoltage or temperature");
    a_term_reg_drive: assert property ((!shutdown_active && term_q[7] && $stable(term_q)) [*2]
        |-> termination_regulator_en == term_q[6]) else $error("termination enable");
    a_vsel_held: assert property (resetn [*4] |-> $stable(memory_core_vsel)) else $error("vsel moved");
    a_pfm_exit_fast: assert property ((!ctrl_discontinuous[0]) [*4] |-> !ctrl_pfm_mode[0]) else $error("exit");
    a_pfm_entry_slow: assert property ($rose(ctrl_pfm_mode[0]) |-> $past(ctrl_discontinuous[0], 16))
        else $error("pfm entry too early");
    a_fault_sdwn: assert property ((|($past(powergood) & ~powergood & rail_enable & ~mask_q & ~rail_fault_exempt))
        && blank_q == 0 |-> ##[1:4] shutdown_active) else $error("fault without shutdown");
endmodule // rfs_seq_checker

// ### rfs_rail_model.sv
// behavioural rail plant: window comparators and switching ticks
module rfs_rail_model #(
    parameter int N_RAILS = 8
) (
    // clock
    input wire logic               clk,
    // rail side
    input wire logic [N_RAILS-1:0] rail_enable,
    input wire logic [N_RAILS-1:0] fault_inject,
    output logic     [N_RAILS-1:0] window_ok,
    output logic     [3:0]         switch_tick
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] div_q = 2'h0;
    // disabled or sagging rails sit outside the window
    assign window_ok = rail_enable & ~fault_inject;
    // one tick per four clocks, slower than the synchronisers
    assign switch_tick = {4{div_q[1]}};
    always @(posedge clk) div_q <= div_q + 2'h1;
endmodule // rfs_rail_model

// ### rfs_seq_tb.sv
// self-checking bench for the rail enable and fault shutdown block
module rfs_seq_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BLANK = 1000;
    localparam int DG = rfs_pkg::DEGLITCH_CYC;
    logic clk, resetn, reg_wr, reg_rd, memory_core_enable_pin, termination_control_input, system_powergood_input;
    logic shutdown_request_n, main_input_undervoltage, aux_input_undervoltage, die_over_temp, shutdown_active;
    logic memory_core_regulator_en, termination_regulator_en, memory_core_dvs_low;
    logic [1:0] memory_voltage_select_pin, memory_core_vsel;
    logic [3:0] ctrl_discontinuous, ctrl_switch_tick, ctrl_pfm_mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, regulator_enable_pin, window_ok, rail_enable, powergood, fault_inj;
    logic [7:0] rail_fault_exempt = 8'hc0;
    logic [1:0] vtab [4] = '{rfs_pkg::VSEL_1V20, rfs_pkg::VSEL_1V35, rfs_pkg::VSEL_1V10, rfs_pkg::VSEL_1V10};
    int n_errors = 0;
    int n_compared = 0;
    rfs_seq #(.N_RAILS(8), .ENABLE_BLANK_CYC(BLANK)) i_rfs_seq (.clk, .resetn, .regulator_enable_pin,
        .memory_core_enable_pin, .termination_control_input, .memory_voltage_select_pin, .system_powergood_input,
        .shutdown_request_n, .window_ok, .rail_fault_exempt, .ctrl_discontinuous, .ctrl_switch_tick,
        .main_input_undervoltage, .aux_input_undervoltage, .die_over_temp, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .rail_enable, .memory_core_regulator_en, .termination_regulator_en, .memory_core_vsel,
        .memory_core_dvs_low, .ctrl_pfm_mode, .powergood, .shutdown_active);
    rfs_rail_model #(.N_RAILS(8)) i_rfs_rail_model (.clk, .rail_enable, .fault_inject(fault_inj), .window_ok,
        .switch_tick(ctrl_switch_tick));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic conclude();
        if (n_errors == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(string w, logic [7:0] got, logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", w, exp, got);
        end
    endtask
    task automatic cyc(int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data is registered: it stands from the edge that takes the read
    task automatic rc(string w, logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hff);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(w, reg_rdata & m, e);
    endtask
    task automatic do_reset();
        @(posedge clk) resetn <= 1'b0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        cyc(4);
    endtask
    task automatic wait_sd(int lim);
        for (int i = 0; i < lim && shutdown_active !== 1'b1; i++) @(negedge clk);
    endtask
    initial begin
        {resetn, reg_wr, reg_rd, memory_core_enable_pin, termination_control_input, die_over_temp} = '0;
        {main_input_undervoltage, aux_input_undervoltage, memory_voltage_select_pin, ctrl_discontinuous} = '0;
        {system_powergood_input, shutdown_request_n, reg_addr, reg_wdata} = 18'h30000;
        {regulator_enable_pin, fault_inj} = '0;
        for (int v = 0; v < 4; v++) begin
            @(posedge clk) memory_voltage_select_pin <= v[1:0];
            do_reset();
            check("vsel", {6'h0, memory_core_vsel}, {6'h0, vtab[v]});
        end
        rc("core_ctrl", rfs_pkg::ADDR_MEM_CORE_CTRL, rfs_pkg::RST_MEM_CORE_CTRL);
        rc("term_ctrl", rfs_pkg::ADDR_TERM_LDO_CTRL, rfs_pkg::RST_TERM_LDO_CTRL);
        rc("mask", rfs_pkg::ADDR_FAULT_MASK_LO, rfs_pkg::RST_FAULT_MASK);
        rc("en_sel", rfs_pkg::ADDR_EN_SEL, rfs_pkg::RST_EN_SEL);
        rc("unmapped", 8'h77, 8'h00);
        wr(rfs_pkg::ADDR_FAULT_REC_LO, 8'hff);
        // voltage setting goes in before any enable
        wr(rfs_pkg::ADDR_MEM_CORE_CTRL, 8'h01);
        @(posedge clk) {termination_control_input, memory_core_enable_pin} <= 2'h3;
        cyc(4);
        check("term_en", termination_regulator_en, 8'h01);
        check("core_en", rail_enable[0], 8'h01);
        check("dvs_low", memory_core_dvs_low, 8'h00);
        @(posedge clk) termination_control_input <= 1'b0;
        cyc(4);
        check("term_en", termination_regulator_en, 8'h00);
        check("dvs_low", memory_core_dvs_low, 8'h01);
        wr(rfs_pkg::ADDR_TERM_LDO_CTRL, 8'hc0);
        cyc(3);
        check("term_en", termination_regulator_en, 8'h01);
        rc("term_ctrl", rfs_pkg::ADDR_TERM_LDO_CTRL, 8'hc0);
        wr(rfs_pkg::ADDR_EN_SEL, 8'h02);
        wr(rfs_pkg::ADDR_REG_EN, 8'h02);
        @(posedge clk) regulator_enable_pin <= 8'h44;
        cyc(4);
        check("rail_en", rail_enable, 8'h47);
        // 16 ticks take about 64 clocks here
        @(posedge clk) ctrl_discontinuous <= 4'hf;
        cyc(50);
        check("pfm", ctrl_pfm_mode, 8'h00);
        cyc(40);
        check("pfm", ctrl_pfm_mode, 8'h0f);
        @(posedge clk) ctrl_discontinuous <= 4'h0;
        cyc(4);
        check("pfm", ctrl_pfm_mode, 8'h00);
        cyc(BLANK + DG);
        check("pg", powergood, 8'h47);
        rc("pg_stat", rfs_pkg::ADDR_PG_STAT_LO, 8'h47);
        // masked rail 1 and exempt rail 6 both leave the window
        wr(rfs_pkg::ADDR_FAULT_MASK_LO, 8'h02);
        @(posedge clk) fault_inj <= 8'h42;
        cyc(DG + 20);
        check("pg", powergood, 8'h05);
        check("sdwn", shutdown_active, 8'h00);
        @(posedge clk) fault_inj <= 8'h00;
        cyc(DG + 20);
        wr(rfs_pkg::ADDR_FAULT_REC_LO, 8'hff);
        @(posedge clk) system_powergood_input <= 1'b0;
        cyc(4);
        @(posedge clk) system_powergood_input <= 1'b1;
        @(posedge clk) fault_inj <= 8'h04;
        cyc(DG + 50);
        check("sdwn", shutdown_active, 8'h00);
        @(posedge clk) fault_inj <= 8'h00;
        cyc(1500);
        check("sdwn", shutdown_active, 8'h00);
        // a sag shorter than the deglitch must not trip
        @(posedge clk) fault_inj <= 8'h04;
        cyc(DG - 20);
        @(posedge clk) fault_inj <= 8'h00;
        cyc(40);
        check("sdwn", shutdown_active, 8'h00);
        @(posedge clk) fault_inj <= 8'h04;
        cyc(DG - 20);
        check("sdwn", shutdown_active, 8'h00);
        wait_sd(60);
        check("sdwn", shutdown_active, 8'h01);
        cyc(20);
        check("rail_en", rail_enable, 8'h00);
        rc("fault_rec", rfs_pkg::ADDR_FAULT_REC_LO, 8'h04, 8'h04);
        @(posedge clk) {regulator_enable_pin, memory_core_enable_pin, fault_inj} <= 17'h0;
        do_reset();
        rc("fault_rec", rfs_pkg::ADDR_FAULT_REC_LO, 8'h04, 8'h04);
        // rail 3 never reaches its window; only the enable blank holds off the trip
        @(posedge clk) {regulator_enable_pin, fault_inj} <= 16'h0808;
        cyc(BLANK - 100);
        check("sdwn", shutdown_active, 8'h00);
        wait_sd(300);
        check("sdwn", shutdown_active, 8'h01);
        @(posedge clk) {regulator_enable_pin, fault_inj} <= 16'h0;
        for (int k = 0; k < 5; k++) begin
            do_reset();
            case (k)
                0: @(posedge clk) main_input_undervoltage <= 1'b1;
                1: @(posedge clk) aux_input_undervoltage <= 1'b1;
                2: @(posedge clk) die_over_temp <= 1'b1;
                3: @(posedge clk) shutdown_request_n <= 1'b0;
                default: wr(rfs_pkg::ADDR_FORCED_SDWN, 8'h01);
            endcase
            wait_sd(20);
            check("sdwn", shutdown_active, 8'h01);
            @(posedge clk) {main_input_undervoltage, aux_input_undervoltage, die_over_temp, shutdown_request_n} <= 4'h1;
        end
        conclude();
    end
    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule // rfs_seq_tb
bind rfs_seq rfs_seq_checker #(.N_RAILS(N_RAILS)) i_rfs_seq_checker (.clk, .resetn, .shutdown_request_n,
    .memory_core_enable_pin,
    .system_powergood_input, .rail_fault_exempt, .ctrl_discontinuous, .main_input_undervoltage,
    .aux_input_undervoltage, .die_over_temp, .reg_wr, .reg_addr, .reg_wdata, .rail_enable, .memory_core_regulator_en,
    .termination_regulator_en, .memory_core_vsel, .ctrl_pfm_mode, .powergood, .shutdown_active);
